// File: agc_cfg.svh
`ifndef AGC_CFG_SVH
`define AGC_CFG_SVH

// ****************************************
// Register map
// ****************************************
`define AGC_LOOP_CONTROL_ADDR 6'h1D
`define AGC_LOOP_CONTROL_RST  8'h91
`define AGC_HYST_MSB          7
`define AGC_HYST_LSB          6
`define AGC_WAIT_MSB          5
`define AGC_WAIT_LSB          4
`define AGC_HOLD_MSB          3
`define AGC_HOLD_LSB          2
`define AGC_FILT_MSB          1
`define AGC_FILT_LSB          0

// ****************************************
// Loop constants
// ****************************************
`define AGC_WAIT_UNIT         6'h08
`define AGC_FILT_MIN_LEN      7'h08
`define AGC_OOK_STEP_DB       5'h04
`define AGC_GAIN_MAX          3'h7
`define AGC_ANA_GAIN_RST      3'h7
`define AGC_DIG_GAIN_RST      3'h0

// ****************************************
// Dead zone and hysteresis per selector code
// ****************************************
`define AGC_DZ_LO_0           8'h02
`define AGC_DZ_LO_1           8'h02
`define AGC_DZ_LO_2           8'h03
`define AGC_DZ_LO_3           8'h04
`define AGC_DZ_UP_0           8'h02
`define AGC_DZ_UP_1           8'h03
`define AGC_DZ_UP_2           8'h05
`define AGC_DZ_UP_3           8'h08
`define AGC_HYST_0            8'h00
`define AGC_HYST_1            8'h01
`define AGC_HYST_2            8'h02
`define AGC_HYST_3            8'h03

`endif

// File: agc_pkg.sv
package agc_pkg;

  typedef enum logic [1:0] {
    AGC_HOLD_NONE   = 2'h0,
    AGC_HOLD_SYNC   = 2'h1,
    AGC_HOLD_ANALOG = 2'h2,
    AGC_HOLD_ALL    = 2'h3
  } agc_hold_t;

  typedef enum logic [1:0] {
    AGC_ST_ACCUM  = 2'h1,
    AGC_ST_SETTLE = 2'h2
  } agc_state_t;

endpackage : agc_pkg

// File: agc_gain_wait.sv
`timescale 1ns/10ps
`default_nettype none
`include "agc_cfg.svh"

module agc_gain_wait (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       restart,
  input  wire logic       sample_valid,
  input  wire logic [1:0] wait_sel,
  output var  logic       busy_ff,
  output var  logic [5:0] remain_ff
);

  logic [5:0] nxt_remain;

  // Restart beats a sample in the same cycle
  always_comb begin
    nxt_remain = remain_ff;
    if (restart) begin
      nxt_remain = 6'(({4'h0, wait_sel} + 6'h01) * `AGC_WAIT_UNIT);
    end else if (sample_valid && remain_ff != 6'h00) begin
      nxt_remain = remain_ff - 6'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      remain_ff <= 6'h00;
      busy_ff   <= 1'b0;
    end else begin
      remain_ff <= nxt_remain;
      busy_ff   <= (nxt_remain != 6'h00);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_wait_load_count: assert property (
    restart |=> remain_ff == 6'(({4'h0, $past(wait_sel)} + 6'h01) * `AGC_WAIT_UNIT))
    else $error("wait count not loaded from selector");

  a_wait_only_samples: assert property (
    !restart && !sample_valid |=> $stable(remain_ff))
    else $error("wait count moved without a sample");

endmodule : agc_gain_wait
`default_nettype wire

// File: agc_behaviour_control.sv
`timescale 1ns/10ps
`default_nettype none
`include "agc_cfg.svh"

module agc_behaviour_control (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic [5:0] reg_addr,
  input  wire logic       reg_wr_en,
  input  wire logic       reg_rd_en,
  input  wire logic [7:0] reg_wdata,
  output var  logic [7:0] reg_rdata_ff,
  input  wire logic       sample_valid,
  input  wire logic [7:0] sample_mag,
  input  wire logic [7:0] magn_target,
  input  wire logic       ook_mode,
  input  wire logic       sync_found,
  input  wire logic       rx_active,
  output var  logic [2:0] analog_gain_ff,
  output var  logic [2:0] digital_gain_ff,
  output var  logic       gain_step_ff,
  output var  logic       gain_frozen_ff,
  output var  logic [7:0] avg_mag_ff,
  output var  logic [4:0] ook_boundary_db_ff
);

  // ****************************************
  // Decoders
  // ****************************************
  function automatic logic [7:0] dz_lo(input logic [1:0] c);
    case (c)
      2'h0:    dz_lo = `AGC_DZ_LO_0;
      2'h1:    dz_lo = `AGC_DZ_LO_1;
      2'h2:    dz_lo = `AGC_DZ_LO_2;
      default: dz_lo = `AGC_DZ_LO_3;
    endcase
  endfunction : dz_lo

  function automatic logic [7:0] dz_up(input logic [1:0] c);
    case (c)
      2'h0:    dz_up = `AGC_DZ_UP_0;
      2'h1:    dz_up = `AGC_DZ_UP_1;
      2'h2:    dz_up = `AGC_DZ_UP_2;
      default: dz_up = `AGC_DZ_UP_3;
    endcase
  endfunction : dz_up

  function automatic logic [7:0] hyst_of(input logic [1:0] c);
    case (c)
      2'h0:    hyst_of = `AGC_HYST_0;
      2'h1:    hyst_of = `AGC_HYST_1;
      2'h2:    hyst_of = `AGC_HYST_2;
      default: hyst_of = `AGC_HYST_3;
    endcase
  endfunction : hyst_of

  function automatic logic [6:0] filt_last(input logic [1:0] c);
    filt_last = 7'((`AGC_FILT_MIN_LEN << c) - 7'h01);
  endfunction : filt_last

  // ****************************************
  // Control register
  // ****************************************
  logic [7:0] ctrl_ff;
  logic [1:0] hyst_sel;
  logic [1:0] wait_sel;
  logic [1:0] filt_sel;
  logic [1:0] filt_eff;
  agc_pkg::agc_hold_t gain_hold_policy;

  assign hyst_sel         = ctrl_ff[`AGC_HYST_MSB:`AGC_HYST_LSB];
  assign wait_sel         = ctrl_ff[`AGC_WAIT_MSB:`AGC_WAIT_LSB];
  assign gain_hold_policy = agc_pkg::agc_hold_t'(ctrl_ff[`AGC_HOLD_MSB:`AGC_HOLD_LSB]);
  assign filt_sel         = ctrl_ff[`AGC_FILT_MSB:`AGC_FILT_LSB];
  // OOK reuses the selector as a boundary, so averaging drops to its shortest span
  assign filt_eff         = ook_mode ? 2'h0 : filt_sel;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl_ff <= `AGC_LOOP_CONTROL_RST;
    end else if (reg_wr_en && reg_addr == `AGC_LOOP_CONTROL_ADDR) begin
      ctrl_ff <= reg_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_rd_en && reg_addr == `AGC_LOOP_CONTROL_ADDR) begin
      reg_rdata_ff <= ctrl_ff;
    end else begin
      reg_rdata_ff <= 8'h00;
    end
  end

  // ****************************************
  // Hold policy
  // ****************************************
  logic sync_seen_ff;
  logic analog_held;
  logic digital_held;

  // A sync in the same cycle as rx drop still latches
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sync_seen_ff <= 1'b0;
    end else if (sync_found) begin
      sync_seen_ff <= 1'b1;
    end else if (!rx_active) begin
      sync_seen_ff <= 1'b0;
    end
  end

  assign analog_held  = (gain_hold_policy == agc_pkg::AGC_HOLD_ANALOG) ||
                        (gain_hold_policy == agc_pkg::AGC_HOLD_ALL) ||
                        (gain_hold_policy == agc_pkg::AGC_HOLD_SYNC && sync_seen_ff);
  assign digital_held = (gain_hold_policy == agc_pkg::AGC_HOLD_ALL) ||
                        (gain_hold_policy == agc_pkg::AGC_HOLD_SYNC && sync_seen_ff);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      gain_frozen_ff <= 1'b0;
    end else begin
      gain_frozen_ff <= analog_held && digital_held;
    end
  end

  // ****************************************
  // Averaging and decision
  // ****************************************
  agc_pkg::agc_state_t state_ff;
  logic [13:0]        acc_ff;
  logic [6:0]         cnt_ff;
  logic [13:0]        sum_fin;
  logic [7:0]         avg;
  logic signed [9:0]  dev;
  logic signed [9:0]  up_lim;
  logic signed [9:0]  lo_lim;
  logic               eval_now;
  logic               want_down;
  logic               want_up;
  logic               last_up_ff;
  logic               last_down_ff;
  logic               wait_busy;
  logic [2:0]         nxt_analog;
  logic [2:0]         nxt_digital;
  logic               step_now;

  assign sum_fin  = acc_ff + {6'h00, sample_mag};
  assign eval_now = (state_ff == agc_pkg::AGC_ST_ACCUM) && sample_valid &&
                    (cnt_ff == filt_last(filt_eff));

  always_comb begin
    case (filt_eff)
      2'h0:    avg = sum_fin[10:3];
      2'h1:    avg = sum_fin[11:4];
      2'h2:    avg = sum_fin[12:5];
      default: avg = sum_fin[13:6];
    endcase
  end

  // Extra margin only when reversing direction, so the loop does not dither
  assign dev       = $signed({2'b00, avg}) - $signed({2'b00, magn_target});
  assign up_lim    = $signed({2'b00, 8'(dz_up(hyst_sel) + (last_up_ff ? hyst_of(hyst_sel) : 8'h00))});
  assign lo_lim    = $signed({2'b00, 8'(dz_lo(hyst_sel) + (last_down_ff ? hyst_of(hyst_sel) : 8'h00))});
  assign want_down = dev > up_lim;
  assign want_up   = (dev + lo_lim) < 10'sh000;

  // Down trims digital first, up restores analog first
  always_comb begin
    nxt_analog  = analog_gain_ff;
    nxt_digital = digital_gain_ff;
    if (eval_now && want_down) begin
      if (!digital_held && digital_gain_ff != 3'h0) begin
        nxt_digital = digital_gain_ff - 3'h1;
      end else if (!analog_held && analog_gain_ff != 3'h0) begin
        nxt_analog = analog_gain_ff - 3'h1;
      end
    end else if (eval_now && want_up) begin
      if (!analog_held && analog_gain_ff != `AGC_GAIN_MAX) begin
        nxt_analog = analog_gain_ff + 3'h1;
      end else if (!digital_held && digital_gain_ff != `AGC_GAIN_MAX) begin
        nxt_digital = digital_gain_ff + 3'h1;
      end
    end
  end

  assign step_now = (nxt_analog != analog_gain_ff) || (nxt_digital != digital_gain_ff);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      analog_gain_ff  <= `AGC_ANA_GAIN_RST;
      digital_gain_ff <= `AGC_DIG_GAIN_RST;
      gain_step_ff    <= 1'b0;
      last_up_ff      <= 1'b0;
      last_down_ff    <= 1'b0;
    end else begin
      analog_gain_ff  <= nxt_analog;
      digital_gain_ff <= nxt_digital;
      gain_step_ff    <= step_now;
      if (step_now) begin
        last_up_ff   <= want_up;
        last_down_ff <= want_down;
      end
    end
  end

  // Samples during the settle wait are dropped, not accumulated
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_ff <= agc_pkg::AGC_ST_ACCUM;
      acc_ff   <= 14'h0000;
      cnt_ff   <= 7'h00;
    end else begin
      case (state_ff)
        agc_pkg::AGC_ST_ACCUM: begin
          if (eval_now) begin
            acc_ff <= 14'h0000;
            cnt_ff <= 7'h00;
            if (step_now) begin
              state_ff <= agc_pkg::AGC_ST_SETTLE;
            end
          end else if (sample_valid) begin
            acc_ff <= sum_fin;
            cnt_ff <= cnt_ff + 7'h01;
          end
        end
        agc_pkg::AGC_ST_SETTLE: begin
          acc_ff <= 14'h0000;
          cnt_ff <= 7'h00;
          if (!wait_busy) begin
            state_ff <= agc_pkg::AGC_ST_ACCUM;
          end
        end
        default: begin
          state_ff <= agc_pkg::AGC_ST_ACCUM;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      avg_mag_ff <= 8'h00;
    end else if (eval_now) begin
      avg_mag_ff <= avg;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ook_boundary_db_ff <= 5'h00;
    end else begin
      ook_boundary_db_ff <= ook_mode ? 5'(({3'h0, filt_sel} + 5'h01) * `AGC_OOK_STEP_DB) : 5'h00;
    end
  end

  // ****************************************
  // Settle wait
  // ****************************************
  agc_gain_wait u_wait (
    .clock        (clock),
    .sys_rst      (sys_rst),
    .restart      (step_now),
    .sample_valid (sample_valid),
    .wait_sel     (wait_sel),
    .busy_ff      (wait_busy),
    .remain_ff    ()
  );

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_step_taken;
    gain_step_ff && state_ff == agc_pkg::AGC_ST_SETTLE;
  endsequence

  a_step_then_settle: assert property (step_now |=> s_step_taken ##0 wait_busy)
    else $error("gain step without settle wait");

  a_normal_adjusts: assert property (
    eval_now && want_down && gain_hold_policy == agc_pkg::AGC_HOLD_NONE &&
    digital_gain_ff != 3'h0 |=> gain_step_ff && digital_gain_ff == $past(digital_gain_ff) - 3'h1)
    else $error("normal policy did not step gain");

  a_sync_hold_gain: assert property (
    gain_hold_policy == agc_pkg::AGC_HOLD_SYNC && sync_seen_ff |=>
    $stable(analog_gain_ff) && $stable(digital_gain_ff))
    else $error("gain moved after sync under hold code 1");

  a_analog_hold: assert property (
    gain_hold_policy == agc_pkg::AGC_HOLD_ANALOG |=> $stable(analog_gain_ff))
    else $error("analog gain moved under hold code 2");

  a_full_hold: assert property (
    gain_hold_policy == agc_pkg::AGC_HOLD_ALL |=> !gain_step_ff && $stable(digital_gain_ff))
    else $error("gain moved under hold code 3");

  a_filter_span: assert property (
    eval_now && !ook_mode && filt_sel == 2'h3 |-> cnt_ff == 7'h3F)
    else $error("averaging span wrong for code 3");

  a_ook_boundary: assert property (
    ook_mode && filt_sel == 2'h3 |=> ook_boundary_db_ff == 5'h10)
    else $error("OOK boundary not 16 dB for code 3");

  a_dead_zone_quiet: assert property (
    eval_now && !want_up && !want_down |=> !gain_step_ff)
    else $error("gain stepped inside dead zone");

endmodule : agc_behaviour_control
`default_nettype wire

// File: testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "agc_cfg.svh"

module testbench;
  logic       clock;
  logic       sys_rst;
  logic [5:0] reg_addr;
  logic       reg_wr_en;
  logic       reg_rd_en;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata_ff;
  logic       sample_valid;
  logic [7:0] sample_mag;
  logic [7:0] magn_target;
  logic       ook_mode;
  logic       sync_found;
  logic       rx_active;
  logic [2:0] analog_gain_ff;
  logic [2:0] digital_gain_ff;
  logic       gain_step_ff;
  logic       gain_frozen_ff;
  logic [7:0] avg_mag_ff;
  logic [4:0] ook_boundary_db_ff;
  int         num_errors;
  int         samples_checked;
  // ****************************************
  // Reference model state
  // ****************************************
  int         ea;
  int         ed;
  int         hold;
  int         dn;
  int         cnt;
  int         step_at[$];
  logic [7:0] eavg;
  int         dz_up[4] = '{`AGC_DZ_UP_0, `AGC_DZ_UP_1, `AGC_DZ_UP_2, `AGC_DZ_UP_3};
  int         dz_lo[4] = '{`AGC_DZ_LO_0, `AGC_DZ_LO_1, `AGC_DZ_LO_2, `AGC_DZ_LO_3};
  int         hy[4]    = '{`AGC_HYST_0, `AGC_HYST_1, `AGC_HYST_2, `AGC_HYST_3};

  agc_behaviour_control i_dut (
    .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
    .sample_valid(sample_valid), .sample_mag(sample_mag), .magn_target(magn_target),
    .ook_mode(ook_mode), .sync_found(sync_found), .rx_active(rx_active),
    .analog_gain_ff(analog_gain_ff), .digital_gain_ff(digital_gain_ff),
    .gain_step_ff(gain_step_ff), .gain_frozen_ff(gain_frozen_ff),
    .avg_mag_ff(avg_mag_ff), .ook_boundary_db_ff(ook_boundary_db_ff)
  );

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("checks=%0d mismatches=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  // Reset is raised off the edge, since callers may return right on one
  task automatic do_rst();
    @(posedge clock);
    #1 sys_rst = 1'b1;
    repeat (6) @(posedge clock);
    #1 sys_rst = 1'b0;
    ea = 7;
    ed = 0;
    hold = 0;
    cnt = 0;
    step_at.delete();
  endtask : do_rst

  task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    #1 reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    if (a == 6'h1D) hold = d[3:2];
    @(posedge clock);
    #1 reg_wr_en = 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [5:0] a, input logic [7:0] exp);
    @(posedge clock);
    #1 reg_addr = a;
    reg_rd_en = 1'b1;
    @(posedge clock);
    #1 reg_rd_en = 1'b0;
    check(reg_rdata_ff, exp);
  endtask : reg_rd

  // Spaced samples so the settle-to-accumulate turnaround never eats one
  task automatic feed(input int n, input int dev);
    eavg = 8'(int'(magn_target) + dev);
    dn = (dev > 0);
    repeat (n) begin
      @(posedge clock);
      #1 sample_valid = 1'b1;
      sample_mag = eavg;
      cnt++;
      @(posedge clock);
      #1 sample_valid = 1'b0;
      sample_mag = ~eavg;
      @(posedge clock);
    end
  endtask : feed

  // ****************************************
  // Gain model, compared at every step
  // ****************************************
  always @(negedge clock) begin
    if (sys_rst === 1'b0 && gain_step_ff === 1'b1) begin
      step_at.push_back(cnt);
      if (dn != 0) begin
        if (ed > 0) ed--;
        else if (ea > 0 && hold != 2) ea--;
      end else begin
        if (ea < 7 && hold != 2) ea++;
        else if (ed < 7) ed++;
      end
      check(analog_gain_ff, ea);
      check(digital_gain_ff, ed);
      check(avg_mag_ff, eavg);
    end
  end

  initial begin
    #(50 * 40000);
    num_errors++;
    results();
  end

  initial begin
    int len;
    logic [7:0] d;
    sys_rst = 1'b1;
    reg_addr = 6'h00;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_wdata = 8'h00;
    sample_valid = 1'b0;
    sample_mag = 8'h00;
    ook_mode = 1'b0;
    sync_found = 1'b0;
    rx_active = 1'b1;
    num_errors = 0;
    samples_checked = 0;
    void'($urandom(32'hE312AA24));
    magn_target = 8'(40 + $urandom % 40);
    do_rst();
    reg_rd(6'h1D, 8'h91);
    check(analog_gain_ff, 3'h7);
    check(digital_gain_ff, 3'h0);
    check(gain_frozen_ff, 1'b0);
    d = 8'($urandom);
    reg_wr(6'h1D, d);
    reg_wr(6'h1C, ~d);
    reg_rd(6'h1D, d);
    reg_rd(6'h1C, 8'h00);
    $display("test reset_and_register done");
    for (int k = 0; k < 4; k++) begin
      do_rst();
      reg_wr(6'h1D, {2'h2, 2'(k), 2'h0, 2'(k)});
      len = 8 << k;
      feed(2 * len + (k + 1) * 8, 20);
      check(step_at.size(), 2);
      if (step_at.size() == 2) begin
        check(step_at[0], len);
        check(step_at[1], 2 * len + (k + 1) * 8);
      end
    end
    $display("test filter_and_wait done");
    for (int h = 0; h < 4; h++) begin
      do_rst();
      reg_wr(6'h1D, {2'(h), 6'h00});
      feed(8, dz_up[h]);
      check(step_at.size(), 0);
      feed(8, dz_up[h] + 1);
      feed(8, 0);
      feed(8, -(dz_lo[h] + hy[h]));
      check(step_at.size(), 1);
      feed(8, -(dz_lo[h] + hy[h]) - 1);
      check(step_at.size(), 2);
    end
    $display("test hysteresis done");
    do_rst();
    reg_wr(6'h1D, 8'h8C);
    feed(16, 20);
    check(step_at.size(), 0);
    check(gain_frozen_ff, 1'b1);
    do_rst();
    reg_wr(6'h1D, 8'h84);
    feed(8, 20);
    check(step_at.size(), 1);
    @(posedge clock);
    #1 sync_found = 1'b1;
    @(posedge clock);
    #1 sync_found = 1'b0;
    feed(24, 20);
    check(step_at.size(), 1);
    check(gain_frozen_ff, 1'b1);
    @(posedge clock);
    #1 rx_active = 1'b0;
    @(posedge clock);
    #1 rx_active = 1'b1;
    feed(16, 20);
    check(step_at.size(), 2);
    check(gain_frozen_ff, 1'b0);
    do_rst();
    reg_wr(6'h1D, 8'h80);
    feed(8, -20);
    feed(8, 0);
    feed(8, -20);
    feed(8, 0);
    feed(8, 20);
    check(step_at.size(), 3);
    feed(8, 0);
    reg_wr(6'h1D, 8'h88);
    feed(8, 20);
    feed(8, 0);
    feed(8, 20);
    check(step_at.size(), 4);
    check(analog_gain_ff, 3'h7);
    $display("test hold_policy done");
    do_rst();
    ook_mode = 1'b1;
    for (int f = 0; f < 4; f++) begin
      reg_wr(6'h1D, {6'h20, 2'(f)});
      repeat (2) @(posedge clock);
      #1 check(ook_boundary_db_ff, 4 * (f + 1));
    end
    feed(8, 20);
    check(step_at.size(), 1);
    #1 ook_mode = 1'b0;
    repeat (2) @(posedge clock);
    #1 check(ook_boundary_db_ff, 5'h00);
    $display("test ook_boundary done");
    results();
  end
endmodule : testbench

`default_nettype wire
